// ### shared/dfo_pkg.sv
// dfo_pkg: constants for the dynamic fan-floor operating point register bank.
// assumes byte offsets are the printed register offsets times four.
package dfo_pkg;
  // register indices and byte addresses
  localparam logic [7:0] DFO_IDX_FAR1_TARGET = 8'h33;
  localparam logic [7:0] DFO_IDX_LOCAL_TARGET = 8'h34;
  localparam logic [7:0] DFO_IDX_FAR2_TARGET = 8'h35;
  localparam logic [7:0] DFO_IDX_FLOOR_CTRL_A = 8'h36;
  localparam logic [7:0] DFO_IDX_LOCK_CTRL = 8'h40;
  localparam logic [7:0] DFO_IDX_STATUS = 8'h41;
  localparam logic [9:0] DFO_ADDR_FAR1_TARGET = {DFO_IDX_FAR1_TARGET, 2'b00};
  localparam logic [9:0] DFO_ADDR_LOCAL_TARGET = {DFO_IDX_LOCAL_TARGET, 2'b00};
  localparam logic [9:0] DFO_ADDR_FAR2_TARGET = {DFO_IDX_FAR2_TARGET, 2'b00};
  localparam logic [9:0] DFO_ADDR_FLOOR_CTRL_A = {DFO_IDX_FLOOR_CTRL_A, 2'b00};
  localparam logic [9:0] DFO_ADDR_LOCK_CTRL = {DFO_IDX_LOCK_CTRL, 2'b00};
  localparam logic [9:0] DFO_ADDR_STATUS = {DFO_IDX_STATUS, 2'b00};
  // reset values
  localparam logic [7:0] DFO_TARGET_RST = 8'h64;
  localparam logic [7:0] DFO_CTRL_RST = 8'h00;
  // control register fields
  localparam int DFO_BIT_FAR2_CYC_MSB = 0;
  localparam int DFO_BIT_RESERVED = 1;
  localparam int DFO_BIT_FAR1_CAPT = 2;
  localparam int DFO_BIT_LOCAL_CAPT = 3;
  localparam int DFO_BIT_FAR2_CAPT = 4;
  localparam int DFO_BIT_FAR1_DYN = 5;
  localparam int DFO_BIT_LOCAL_DYN = 6;
  localparam int DFO_BIT_FAR2_DYN = 7;
  localparam logic [7:0] DFO_CTRL_WMASK = 8'hFD;
  // lock register field
  localparam int DFO_BIT_LOCK = 1;
  // axi responses
  localparam logic [1:0] DFO_RESP_OKAY = 2'b00;
  localparam logic [1:0] DFO_RESP_SLVERR = 2'b10;
  // bus fsm states
  typedef enum logic [2:0] {
    DFO_ST_IDLE = 3'b001,
    DFO_ST_WRESP = 3'b010,
    DFO_ST_RDATA = 3'b100
  } dfo_bus_st_t;
endpackage : dfo_pkg

// ### rtl/dfo_target_slot.sv
// dfo_target_slot: one 8-bit operating point register with lock and capture.
// assumes the capture pulse lasts one cycle and temperature is a settled reading.
`timescale 1ns/10ps
module dfo_target_slot (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic locked,
  input wire logic capture_en,
  input wire logic capture_pulse,
  input wire logic [7:0] temp_now,
  output logic [7:0] value
);
  import dfo_pkg::*;
  logic [7:0] value_r;
  logic [7:0] value_nxt;
  wire logic do_capture;
  wire logic do_write;

  assign do_capture = capture_en & capture_pulse;
  assign do_write = wr_en & ~locked;
  // capture wins over a software write in the same cycle
  assign value_nxt = do_capture ? temp_now : (do_write ? wr_data : value_r);
  assign value = value_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_r <= DFO_TARGET_RST;
    end else begin
      value_r <= value_nxt;
    end
  end
endmodule : dfo_target_slot

// ### rtl/dfo_regs.sv
// dfo_regs: dynamic fan-floor operating point and control registers behind axi4-lite.
// assumes thermal_throttle_signal and temperature readings are synchronous to aclk.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module dfo_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic thermal_throttle_signal,
  input wire logic [7:0] far1_temp_now,
  input wire logic [7:0] local_temp_now,
  input wire logic [7:0] far2_temp_now,
  output logic [7:0] far1_target_temp,
  output logic [7:0] local_target_temp,
  output logic [7:0] far2_target_temp,
  output logic far1_dynamic_enable,
  output logic local_dynamic_enable,
  output logic far2_dynamic_enable,
  output logic far2_cycle_code_msb,
  output logic regs_locked
);
  import dfo_pkg::*;

  // ----------------------------------------------------------------
  // bus state
  // ----------------------------------------------------------------
  dfo_bus_st_t st_r;
  dfo_bus_st_t st_nxt;
  logic aw_got_r;
  logic w_got_r;
  logic [9:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic awready_r;
  logic wready_r;
  logic arready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [7:0] ctrl_r;
  logic lock_r;
  logic throttle_d_r;
  logic [7:0] far1_q;
  logic [7:0] local_q;
  logic [7:0] far2_q;
  logic [7:0] far1_out_r;
  logic [7:0] local_out_r;
  logic [7:0] far2_out_r;
  logic [7:0] ctrl_out_r;
  logic lock_out_r;

  wire logic aw_hs;
  wire logic w_hs;
  wire logic aw_have;
  wire logic w_have;
  wire logic wr_go;
  wire logic [9:0] wr_addr;
  wire logic [31:0] wr_data;
  wire logic [3:0] wr_strb;
  wire logic wr_lane0;
  wire logic wr_far1;
  wire logic wr_local;
  wire logic wr_far2;
  wire logic wr_ctrl;
  wire logic wr_lock;
  wire logic wr_hit;
  wire logic rd_go;
  wire logic rd_hit;
  wire logic [7:0] rd_byte;
  wire logic [7:0] ctrl_nxt;
  wire logic lock_nxt;
  wire logic throttle_rise;

  // ----------------------------------------------------------------
  // write path: address and data taken in either order
  // ----------------------------------------------------------------
  assign aw_hs = s_axi_awvalid & awready_r;
  assign w_hs = s_axi_wvalid & wready_r;
  assign aw_have = aw_got_r | aw_hs;
  assign w_have = w_got_r | w_hs;
  assign wr_go = (st_r == DFO_ST_IDLE) & aw_have & w_have & ~rd_go;
  assign wr_addr = aw_got_r ? awaddr_r : s_axi_awaddr;
  assign wr_data = w_got_r ? wdata_r : s_axi_wdata;
  assign wr_strb = w_got_r ? wstrb_r : s_axi_wstrb;
  assign wr_lane0 = wr_go & wr_strb[0];
  assign wr_far1 = wr_lane0 & (wr_addr == DFO_ADDR_FAR1_TARGET);
  assign wr_local = wr_lane0 & (wr_addr == DFO_ADDR_LOCAL_TARGET);
  assign wr_far2 = wr_lane0 & (wr_addr == DFO_ADDR_FAR2_TARGET);
  assign wr_ctrl = wr_lane0 & (wr_addr == DFO_ADDR_FLOOR_CTRL_A);
  assign wr_lock = wr_lane0 & (wr_addr == DFO_ADDR_LOCK_CTRL);
  assign wr_hit = (wr_addr == DFO_ADDR_FAR1_TARGET) | (wr_addr == DFO_ADDR_LOCAL_TARGET) |
                  (wr_addr == DFO_ADDR_FAR2_TARGET) | (wr_addr == DFO_ADDR_FLOOR_CTRL_A) |
                  (wr_addr == DFO_ADDR_LOCK_CTRL) | (wr_addr == DFO_ADDR_STATUS);

  // ----------------------------------------------------------------
  // read path: reads go first when both arrive in idle
  // ----------------------------------------------------------------
  assign rd_go = (st_r == DFO_ST_IDLE) & s_axi_arvalid & arready_r;
  assign rd_hit = (s_axi_araddr == DFO_ADDR_FAR1_TARGET) | (s_axi_araddr == DFO_ADDR_LOCAL_TARGET) |
                  (s_axi_araddr == DFO_ADDR_FAR2_TARGET) | (s_axi_araddr == DFO_ADDR_FLOOR_CTRL_A) |
                  (s_axi_araddr == DFO_ADDR_LOCK_CTRL) | (s_axi_araddr == DFO_ADDR_STATUS);
  assign rd_byte = (s_axi_araddr == DFO_ADDR_FAR1_TARGET) ? far1_q :
                   (s_axi_araddr == DFO_ADDR_LOCAL_TARGET) ? local_q :
                   (s_axi_araddr == DFO_ADDR_FAR2_TARGET) ? far2_q :
                   (s_axi_araddr == DFO_ADDR_FLOOR_CTRL_A) ? ctrl_r :
                   (s_axi_araddr == DFO_ADDR_LOCK_CTRL) ? {6'h00, lock_r, 1'b0} :
                   (s_axi_araddr == DFO_ADDR_STATUS) ? {5'h00, thermal_throttle_signal, 1'b0, lock_r} :
                   8'h00;

  // ----------------------------------------------------------------
  // control and lock
  // ----------------------------------------------------------------
  // reserved bit masked out, lock blocks writes
  assign ctrl_nxt = (wr_ctrl & ~lock_r) ? (wr_data[7:0] & DFO_CTRL_WMASK) : ctrl_r;
  // lock only ever sets
  assign lock_nxt = lock_r | (wr_lock & wr_data[DFO_BIT_LOCK]);
  assign throttle_rise = thermal_throttle_signal & ~throttle_d_r;

  // ----------------------------------------------------------------
  // bus fsm
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      DFO_ST_IDLE: begin
        if (rd_go) begin
          st_nxt = DFO_ST_RDATA;
        end else if (wr_go) begin
          st_nxt = DFO_ST_WRESP;
        end
      end
      DFO_ST_WRESP: begin
        if (s_axi_bready) begin
          st_nxt = DFO_ST_IDLE;
        end
      end
      DFO_ST_RDATA: begin
        if (s_axi_rready) begin
          st_nxt = DFO_ST_IDLE;
        end
      end
      default: begin
        st_nxt = DFO_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= DFO_ST_IDLE;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 10'h000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else begin
      st_r <= st_nxt;
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end else begin
        if (aw_hs) begin
          aw_got_r <= 1'b1;
          awaddr_r <= s_axi_awaddr;
        end
        if (w_hs) begin
          w_got_r <= 1'b1;
          wdata_r <= s_axi_wdata;
          wstrb_r <= s_axi_wstrb;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
    end else begin
      awready_r <= (st_nxt == DFO_ST_IDLE) & ~(aw_got_r | aw_hs);
      wready_r <= (st_nxt == DFO_ST_IDLE) & ~(w_got_r | w_hs);
      arready_r <= (st_nxt == DFO_ST_IDLE) & ~rd_go;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= DFO_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= DFO_RESP_OKAY;
    end else begin
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? DFO_RESP_OKAY : DFO_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rdata_r <= {24'h000000, rd_byte};
        rresp_r <= rd_hit ? DFO_RESP_OKAY : DFO_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // register state and registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= DFO_CTRL_RST;
      lock_r <= 1'b0;
      throttle_d_r <= 1'b0;
      far1_out_r <= DFO_TARGET_RST;
      local_out_r <= DFO_TARGET_RST;
      far2_out_r <= DFO_TARGET_RST;
      ctrl_out_r <= DFO_CTRL_RST;
      lock_out_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      lock_r <= lock_nxt;
      throttle_d_r <= thermal_throttle_signal;
      far1_out_r <= far1_q;
      local_out_r <= local_q;
      far2_out_r <= far2_q;
      ctrl_out_r <= ctrl_r;
      lock_out_r <= lock_r;
    end
  end

  // ----------------------------------------------------------------
  // operating point registers
  // ----------------------------------------------------------------
  dfo_target_slot u_far1 (
    .aclk(aclk), .aresetn(aresetn), .wr_en(wr_far1), .wr_data(wr_data[7:0]), .locked(lock_r),
    .capture_en(ctrl_r[DFO_BIT_FAR1_CAPT]), .capture_pulse(throttle_rise),
    .temp_now(far1_temp_now), .value(far1_q)
  );
  dfo_target_slot u_local (
    .aclk(aclk), .aresetn(aresetn), .wr_en(wr_local), .wr_data(wr_data[7:0]), .locked(lock_r),
    .capture_en(ctrl_r[DFO_BIT_LOCAL_CAPT]), .capture_pulse(throttle_rise),
    .temp_now(local_temp_now), .value(local_q)
  );
  dfo_target_slot u_far2 (
    .aclk(aclk), .aresetn(aresetn), .wr_en(wr_far2), .wr_data(wr_data[7:0]), .locked(lock_r),
    .capture_en(ctrl_r[DFO_BIT_FAR2_CAPT]), .capture_pulse(throttle_rise),
    .temp_now(far2_temp_now), .value(far2_q)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign far1_target_temp = far1_out_r;
  assign local_target_temp = local_out_r;
  assign far2_target_temp = far2_out_r;
  // enables gate the external floor engine; clear leaves floor untouched
  assign far1_dynamic_enable = ctrl_out_r[DFO_BIT_FAR1_DYN];
  assign local_dynamic_enable = ctrl_out_r[DFO_BIT_LOCAL_DYN];
  assign far2_dynamic_enable = ctrl_out_r[DFO_BIT_FAR2_DYN];
  // msb of the remote 2 cycle code; low bits and cycle counting live downstream
  assign far2_cycle_code_msb = ctrl_out_r[DFO_BIT_FAR2_CYC_MSB];
  assign regs_locked = lock_out_r;
endmodule : dfo_regs

// ### bench/dfo_regs_monitor.sv
// dfo_regs_monitor: handshake and lock properties of the operating point bank.
// assumes it is bound to dfo_regs and sees only its ports.
`timescale 1ns/10ps
module dfo_regs_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic thermal_throttle_signal,
  input wire logic [7:0] far1_target_temp,
  input wire logic [7:0] local_target_temp,
  input wire logic [7:0] far2_target_temp,
  input wire logic far1_dynamic_enable,
  input wire logic local_dynamic_enable,
  input wire logic far2_dynamic_enable,
  input wire logic far2_cycle_code_msb,
  input wire logic regs_locked
);
  logic tt_d_r;
  logic [3:0] rise_r;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // recent throttle rises, during which a capture may still move a target
  always_ff @(posedge aclk) begin
    tt_d_r <= thermal_throttle_signal;
    rise_r <= aresetn ? {rise_r[2:0], thermal_throttle_signal & ~tt_d_r} : 4'h0;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_arvalid;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence held_lock;
    regs_locked && $past(regs_locked, 3) && rise_r == 4'h0;
  endsequence
  write_answer_a: assert property (wr_take |=> s_axi_bvalid)
    else $error("write response missing one cycle after the pair");
  read_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read data missing one cycle after the address");
  busy_refuse_a: assert property (s_axi_bvalid || s_axi_rvalid |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("ready raised while a response is pending");
  lock_sticky_a: assert property (regs_locked |=> regs_locked)
    else $error("lock dropped without reset");
  lock_far1_a: assert property (held_lock |-> $stable(far1_target_temp))
    else $error("remote 1 target moved while locked");
  lock_local_a: assert property (held_lock |-> $stable(local_target_temp))
    else $error("local target moved while locked");
  lock_far2_a: assert property (held_lock |-> $stable(far2_target_temp))
    else $error("remote 2 target moved while locked");
  lock_ctrl_a: assert property (held_lock |-> $stable({far1_dynamic_enable, local_dynamic_enable,
    far2_dynamic_enable, far2_cycle_code_msb})) else $error("control bits moved while locked");
endmodule : dfo_regs_monitor
bind dfo_regs dfo_regs_monitor i_dfo_regs_monitor (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .thermal_throttle_signal,
  .far1_target_temp, .local_target_temp, .far2_target_temp, .far1_dynamic_enable, .local_dynamic_enable,
  .far2_dynamic_enable, .far2_cycle_code_msb, .regs_locked);

// ### bench/dfo_sensor_model.sv
// dfo_sensor_model: stands in for the temperature readings and the throttle source.
// assumes the bench moves trip and base just after a rising edge.
`timescale 1ns/10ps
module dfo_sensor_model (
  input wire logic aclk,
  input wire logic trip,
  input wire logic [7:0] base,
  output logic thermal_throttle_signal,
  output logic [7:0] far1_temp_now,
  output logic [7:0] local_temp_now,
  output logic [7:0] far2_temp_now
);
  initial begin
    thermal_throttle_signal = 1'b0;
    far1_temp_now = 8'h00;
    local_temp_now = 8'h00;
    far2_temp_now = 8'h00;
  end
  // readings land one cycle after the request, like a sampled converter
  always @(posedge aclk) begin
    thermal_throttle_signal <= trip;
    far1_temp_now <= base;
    local_temp_now <= base + 8'h11;
    far2_temp_now <= base + 8'h22;
  end
endmodule : dfo_sensor_model

// ### bench/tb.sv
// tb: register bank scenarios over axi4-lite with a sensor model.
// assumes dfo_regs and dfo_pkg are compiled first.
`timescale 1ns/10ps
module tb;
  import dfo_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] s_axi_awaddr = 10'h000;
  logic [9:0] s_axi_araddr = 10'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, thermal_throttle_signal;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] far1_temp_now, local_temp_now, far2_temp_now, far1_target_temp, local_target_temp, far2_target_temp;
  logic far1_dynamic_enable, local_dynamic_enable, far2_dynamic_enable, far2_cycle_code_msb, regs_locked;
  logic trip = 1'b0;
  logic [7:0] base = 8'h00;
  logic [7:0] tgt [3];
  logic [9:0] ta [3] = '{DFO_ADDR_FAR1_TARGET, DFO_ADDR_LOCAL_TARGET, DFO_ADDR_FAR2_TARGET};
  int errors = 0;
  int comparisons = 0;
  always #5 aclk = ~aclk;
  dfo_regs i_dfo_regs (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .thermal_throttle_signal,
    .far1_temp_now, .local_temp_now, .far2_temp_now, .far1_target_temp, .local_target_temp, .far2_target_temp,
    .far1_dynamic_enable, .local_dynamic_enable, .far2_dynamic_enable, .far2_cycle_code_msb, .regs_locked);
  dfo_sensor_model i_dfo_sensor_model (.aclk, .trip, .base, .thermal_throttle_signal, .far1_temp_now,
    .local_temp_now, .far2_temp_now);
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one bus transfer; a write offers address and data together
  task automatic xfer(input logic rd_op, input logic [9:0] a, input logic [7:0] d, input logic [1:0] er,
    input logic [31:0] ed);
    int n;
    logic aw;
    logic w;
    logic done;
    n = 0;
    aw = !rd_op;
    w = !rd_op;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= aw;
    s_axi_wvalid <= w;
    s_axi_bready <= aw;
    s_axi_arvalid <= rd_op;
    s_axi_rready <= rd_op;
    while (!done && n < 50) begin
      @(posedge aclk);
      n++;
      if (rd_op && s_axi_rvalid) begin
        done = 1'b1;
        s_axi_rready <= 1'b0;
        chk($sformatf("rdata at %h", a), ed, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      end else if (!rd_op && !aw && !w && s_axi_bvalid) begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      end
      if (rd_op && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (!done) begin
      errors++;
      tally_and_finish();
    end
  endtask : xfer
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) xfer(1'b1, ta[i], 8'h00, DFO_RESP_OKAY, {24'h0, DFO_TARGET_RST});
    xfer(1'b1, DFO_ADDR_FLOOR_CTRL_A, 8'h00, DFO_RESP_OKAY, {24'h0, DFO_CTRL_RST});
    for (int i = 0; i < 3; i++) begin
      tgt[i] = 8'h50 + 8'(i);
      xfer(1'b0, ta[i], tgt[i], DFO_RESP_OKAY, 32'h0);
      xfer(1'b1, ta[i], 8'h00, DFO_RESP_OKAY, {24'h0, tgt[i]});
    end
    chk("targets", {8'h0, tgt[2], tgt[1], tgt[0]}, {8'h0, far2_target_temp, local_target_temp, far1_target_temp});
    for (int b = 0; b < 8; b++) begin
      xfer(1'b0, DFO_ADDR_FLOOR_CTRL_A, 8'h01 << b, DFO_RESP_OKAY, 32'h0);
      xfer(1'b1, DFO_ADDR_FLOOR_CTRL_A, 8'h00, DFO_RESP_OKAY, (32'h1 << b) & 32'hFD);
      chk("ctrl ports", {28'h0, b == 7, b == 6, b == 5, b == 0}, {28'h0, far2_dynamic_enable,
        local_dynamic_enable, far1_dynamic_enable, far2_cycle_code_msb});
    end
    xfer(1'b0, 10'h0C0, 8'hAA, DFO_RESP_SLVERR, 32'h0);
    xfer(1'b1, 10'h0C0, 8'h00, DFO_RESP_SLVERR, 32'h0);
    // a write with no byte lane enabled leaves the register alone
    s_axi_wstrb <= 4'h0;
    xfer(1'b0, ta[0], 8'h99, DFO_RESP_OKAY, 32'h0);
    s_axi_wstrb <= 4'hF;
    xfer(1'b1, ta[0], 8'h00, DFO_RESP_OKAY, {24'h0, tgt[0]});
    for (int k = 0; k < 3; k++) begin
      xfer(1'b0, DFO_ADDR_FLOOR_CTRL_A, 8'h04 << k, DFO_RESP_OKAY, 32'h0);
      base <= 8'h20 + 8'(8 * k);
      tgt[k] = 8'h20 + 8'(8 * k) + 8'(17 * k);
      trip <= 1'b1;
      repeat (5) @(posedge aclk);
      // status shows the throttle level while it is high
      xfer(1'b1, DFO_ADDR_STATUS, 8'h00, DFO_RESP_OKAY, 32'h4);
      // readings move on while throttle stays high; no second capture
      base <= 8'hA0;
      repeat (5) @(posedge aclk);
      trip <= 1'b0;
      repeat (3) @(posedge aclk);
      for (int j = 0; j < 3; j++) xfer(1'b1, ta[j], 8'h00, DFO_RESP_OKAY, {24'h0, tgt[j]});
    end
    xfer(1'b0, DFO_ADDR_LOCK_CTRL, 8'h02, DFO_RESP_OKAY, 32'h0);
    for (int j = 0; j < 3; j++) xfer(1'b0, ta[j], 8'h77, DFO_RESP_OKAY, 32'h0);
    for (int j = 0; j < 3; j++) xfer(1'b1, ta[j], 8'h00, DFO_RESP_OKAY, {24'h0, tgt[j]});
    xfer(1'b0, DFO_ADDR_FLOOR_CTRL_A, 8'hE3, DFO_RESP_OKAY, 32'h0);
    xfer(1'b1, DFO_ADDR_FLOOR_CTRL_A, 8'h00, DFO_RESP_OKAY, 32'h10);
    xfer(1'b0, DFO_ADDR_LOCK_CTRL, 8'h00, DFO_RESP_OKAY, 32'h0);
    xfer(1'b1, DFO_ADDR_STATUS, 8'h00, DFO_RESP_OKAY, 32'h1);
    chk("regs_locked", 32'h1, {31'h0, regs_locked});
    tally_and_finish();
  end
endmodule : tb
